// ### core/tfp_port.sv
// tdm frame timing port with a classic wishbone register slave
//
// Design decisions made here: the address map and the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
// How it works
// [RULE1] a frame holds up to 48 slots of eight bits, one per bit clock
// [RULE2] each 24-bit channel flow fills three consecutive slots
// [RULE3] slave bit clock may run at any rate; no fixed ratio is assumed
// [RULE4] master bit clock is a buffered master clock, not divided to the sample rate
// [RULE5] each rising frame sync edge starts a new frame
// [RULE6] without early start, first bit goes out on the second rising edge
// [RULE7] early start moves the first bit half a bit clock sooner
// [RULE8] early start plus inversion puts the first bit on the first rising edge
// [RULE9] frame sync high time comes from an 11-bit width or half duty
// [RULE10] bits per frame equal the clock ratio; slots are that over eight, at most 48
// [RULE11] with the high-rate master clock the bit clock stays at or below 6.4 MHz; as slave the code only flags a faster clock in overrate
// [RULE12] the clock source may stop the bit clock after the wanted data
// [RULE13] slave output only moves on bit clock edges, so bursts are tolerated
// [RULE14] as master the bit clock runs on through the whole frame
// [RULE15] the serial driver floats during slots that are not enabled
// [RULE16] past the 48-slot window drive at most 16 bit clocks, then low
// [RULE17] channel data leaves its start slot most significant bit first
// [RULE18] bit and slot counters restart at each detected frame sync edge
// [RULE19] the receiver samples on the edge opposite the launch edge
module tfp_port (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [31:0] wb_dat_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic        wb_we_i,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	output logic [31:0]      wb_dat_o,
	output logic             wb_ack_o,
	input  wire logic        port_bit_clock_i,
	output logic             port_bit_clock_o,
	output logic             port_bit_clock_oe,
	input  wire logic        port_frame_sync_i,
	output logic             port_frame_sync_o,
	output logic             port_frame_sync_oe,
	output logic             port_serial_out_o,
	output logic             port_serial_out_oe
);
	typedef struct packed {
		tfp_pkg::tfp_ctrl_t ctrl;
		logic [10:0]        fs_width;
		logic [11:0]        frame_len;
		logic [7:0]         half;
		logic [47:0]        slot_en;
		logic [3:0][5:0]    loc;
		logic [3:0][23:0]   data;
		logic               wb_ack;
		logic [31:0]        wb_dat;
		logic               sclk_prev;
		logic               fs_prev;
		logic               armed;
		logic               active;
		logic [11:0]        idx;
		logic [11:0]        bits_cnt;
		logic [11:0]        bits_last;
		logic [7:0]         period_cnt;
		logic               overrate;
		logic               bclk_o;
		logic               bclk_oe;
		logic               fs_o;
		logic               fs_oe;
		logic               sd_o;
		logic               sd_oe;
	} tfp_state_t;

	tfp_state_t            s_reg;
	tfp_state_t            s_next;
	tfp_pkg::tfp_gen_cfg_t gen_cfg;
	logic                  gen_bclk;
	logic                  gen_fs;
	logic [31:0]           w;
	logic [31:0]           rdat;
	logic                  req;
	logic                  sclk;
	logic                  fs;
	logic                  eff;
	logic                  eff_prev;
	logic                  rise;
	logic                  fall;
	logic                  start;
	logic                  launch;
	logic                  ovr_set;
	logic                  ovr_clr;
	logic [1:0]            out_bits;
	logic [7:0]            half_eff;

	// byte-lane merge of a wishbone write into an old register value
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (sel[b]) begin
				r[b*8 +: 8] = wd[b*8 +: 8];
			end
		end
		return r;
	endfunction

	// usable slots of a frame: the bit count over eight, never above the window
	function automatic logic [5:0] usable_slots(input logic [11:0] bits);
		logic [8:0] q;
		q = bits[11:3];
		return (q > 9'(tfp_pkg::MAX_SLOTS)) ? 6'(tfp_pkg::MAX_SLOTS) : q[5:0]; // [RULE10]
	endfunction

	// enable and data for one bit position; the lowest channel wins a shared slot
	function automatic logic [1:0] slot_out(input logic [11:0] idx, input logic [47:0] en,
	                                        input logic [3:0][5:0] loc, input logic [3:0][23:0] dat);
		logic [11:0] base;
		logic [11:0] off;
		logic        d;
		d = 1'b0;
		base = 12'h000;
		off = 12'h000;
		for (int c = tfp_pkg::CH_COUNT - 1; c >= 0; c--) begin
			base = {3'b000, loc[c], 3'b000};
			off = idx - base;
			// a flow spans three slots and leaves msb first
			if (idx >= base && off < 12'(tfp_pkg::FLOW_BITS)) begin // [RULE2]
				d = dat[c][5'(5'd23 - off[4:0])]; // [RULE17]
			end
		end
		if (idx < tfp_pkg::WINDOW_BITS) begin
			return {en[idx[8:3]], d}; // [RULE15]
		end else if (en[tfp_pkg::MAX_SLOTS - 1]) begin
			// a flow begun in the last slots spills over, then the line goes low
			return {1'b1, (idx < tfp_pkg::TAIL_END) ? d : 1'b0}; // [RULE16]
		end
		return 2'b00;
	endfunction

	// master clock is a fixed divider of clk, clamped under the high-rate setting
	always_comb begin
		half_eff = (s_reg.half == 8'h00) ? 8'h01 : s_reg.half;
		if (s_reg.ctrl.high_rate && half_eff < tfp_pkg::MIN_HALF_CYC) begin
			half_eff = tfp_pkg::MIN_HALF_CYC; // [RULE11]
		end
		gen_cfg.run = s_reg.ctrl.enable & s_reg.ctrl.master;
		gen_cfg.invert = s_reg.ctrl.invert;
		gen_cfg.half_duty = s_reg.ctrl.half_duty;
		gen_cfg.half = half_eff;
		gen_cfg.frame_len = s_reg.frame_len;
		gen_cfg.fs_width = s_reg.fs_width;
	end

	tfp_master_gen u_gen (
		.clk        (clk),
		.rst        (rst),
		.cfg        (gen_cfg),
		.bit_clock  (gen_bclk),
		.frame_sync (gen_fs)
	);

	// register reads: unmapped addresses answer zero
	always_comb begin
		unique case ({wb_adr_i[7:2], 2'b00})
			tfp_pkg::ADDR_CTRL:     rdat = {26'h0, s_reg.ctrl};
			tfp_pkg::ADDR_FS_WIDTH: rdat = {21'h0, s_reg.fs_width};
			tfp_pkg::ADDR_TIMING:   rdat = {8'h00, s_reg.half, 4'h0, s_reg.frame_len};
			tfp_pkg::ADDR_SLOT_LO:  rdat = s_reg.slot_en[31:0];
			tfp_pkg::ADDR_SLOT_HI:  rdat = {16'h0000, s_reg.slot_en[47:32]};
			tfp_pkg::ADDR_CH_LOC:   rdat = {2'b00, s_reg.loc[3], 2'b00, s_reg.loc[2],
			                                2'b00, s_reg.loc[1], 2'b00, s_reg.loc[0]};
			8'h18:                  rdat = {8'h00, s_reg.data[0]};
			8'h1C:                  rdat = {8'h00, s_reg.data[1]};
			8'h20:                  rdat = {8'h00, s_reg.data[2]};
			8'h24:                  rdat = {8'h00, s_reg.data[3]};
			tfp_pkg::ADDR_STATUS:   rdat = {6'h00, s_reg.active, s_reg.overrate, 2'b00,
			                                usable_slots(s_reg.bits_last), 4'h0, s_reg.bits_last};
			default:                rdat = 32'h0000_0000;
		endcase
	end

	// next state: bus slave, edge detection, frame tracking and the serial driver
	always_comb begin
		s_next = s_reg;
		s_next.wb_ack = 1'b0;
		req = wb_cyc_i & wb_stb_i & ~s_reg.wb_ack;
		w = 32'h0000_0000;
		ovr_set = 1'b0;
		ovr_clr = 1'b0;
		out_bits = 2'b00;

		// one-wait-state answer; ack drops the cycle after it is given
		if (req) begin
			s_next.wb_ack = 1'b1;
			s_next.wb_dat = rdat;
			if (wb_we_i) begin
				w = merge(rdat, wb_dat_i, wb_sel_i);
				unique case ({wb_adr_i[7:2], 2'b00})
					tfp_pkg::ADDR_CTRL:     s_next.ctrl = w[5:0];
					tfp_pkg::ADDR_FS_WIDTH: s_next.fs_width = w[10:0]; // [RULE9]
					tfp_pkg::ADDR_TIMING: begin
						s_next.frame_len = w[11:0];
						s_next.half = w[23:16];
					end
					tfp_pkg::ADDR_SLOT_LO:  s_next.slot_en[31:0] = w;
					tfp_pkg::ADDR_SLOT_HI:  s_next.slot_en[47:32] = w[15:0];
					tfp_pkg::ADDR_CH_LOC: begin
						s_next.loc[0] = w[5:0];
						s_next.loc[1] = w[13:8];
						s_next.loc[2] = w[21:16];
						s_next.loc[3] = w[29:24];
					end
					8'h18:                  s_next.data[0] = w[23:0];
					8'h1C:                  s_next.data[1] = w[23:0];
					8'h20:                  s_next.data[2] = w[23:0];
					8'h24:                  s_next.data[3] = w[23:0];
					tfp_pkg::ADDR_STATUS:   ovr_clr = wb_sel_i[3] & wb_dat_i[tfp_pkg::ST_OVERRATE_BIT];
					default: begin
					end
				endcase
			end
		end

		// as master the pins follow the generator; as slave they float
		s_next.bclk_o = gen_bclk; // [RULE4]
		s_next.fs_o = gen_fs;
		s_next.bclk_oe = s_reg.ctrl.enable & s_reg.ctrl.master;
		s_next.fs_oe = s_reg.ctrl.enable & s_reg.ctrl.master;

		// inversion swaps which physical edge counts as rising
		sclk = s_reg.ctrl.master ? s_reg.bclk_o : port_bit_clock_i;
		fs = s_reg.ctrl.master ? s_reg.fs_o : port_frame_sync_i;
		eff = sclk ^ s_reg.ctrl.invert;
		eff_prev = s_reg.sclk_prev ^ s_reg.ctrl.invert;
		s_next.sclk_prev = sclk;
		rise = s_reg.ctrl.enable & eff & ~eff_prev;
		fall = s_reg.ctrl.enable & ~eff & eff_prev;
		start = rise & fs & ~s_reg.fs_prev; // [RULE5]
		// early start launches on falling edges, half a clock ahead of the default
		launch = s_reg.ctrl.early ? fall : (rise & ~start); // [RULE7] [RULE8]

		if (!s_reg.ctrl.enable) begin
			s_next.armed = 1'b0;
			s_next.active = 1'b0;
			s_next.sd_o = 1'b0;
			s_next.sd_oe = 1'b0;
			s_next.period_cnt = 8'h00;
		end else begin
			// only the period count advances between edges, so a stopped clock just holds position
			if (rise) begin // [RULE13] [RULE12]
				s_next.fs_prev = fs;
				s_next.period_cnt = 8'h00;
				// the limit is only checked, a slave cannot slow the far clock
				if (s_reg.ctrl.high_rate && !s_reg.ctrl.master && s_reg.period_cnt != 8'hFF &&
				    s_reg.period_cnt + 8'h01 < tfp_pkg::MIN_PERIOD_CYC) begin
					ovr_set = 1'b1; // [RULE11]
				end
				// bits per frame are measured, never assumed from a ratio
				s_next.bits_cnt = (s_reg.bits_cnt == 12'hFFF) ? s_reg.bits_cnt : s_reg.bits_cnt + 12'h001; // [RULE3]
				if (start) begin
					s_next.bits_last = s_reg.bits_cnt; // [RULE10]
					s_next.bits_cnt = 12'h001;
					s_next.idx = 12'h000; // [RULE18]
					s_next.armed = 1'b1;
					s_next.active = 1'b0;
				end
			end else if (s_reg.period_cnt != 8'hFF) begin
				s_next.period_cnt = s_reg.period_cnt + 8'h01;
			end
			// without early start, the first launch after the start edge lands on the second rising edge
			if (launch && (s_reg.armed || s_reg.active)) begin // [RULE6]
				out_bits = slot_out(s_reg.idx, s_reg.slot_en, s_reg.loc, s_reg.data); // [RULE1]
				s_next.armed = 1'b0;
				s_next.active = 1'b1;
				s_next.sd_oe = out_bits[1]; // [RULE15]
				s_next.sd_o = out_bits[1] & out_bits[0];
				s_next.idx = (s_reg.idx == 12'hFFF) ? s_reg.idx : s_reg.idx + 12'h001; // [RULE16]
			end
		end
		// a new overrate event wins over a clear in the same cycle
		s_next.overrate = (s_reg.overrate & ~ovr_clr) | ovr_set;
	end

	// every piece of state outside the clock generator lives in one register
	always_ff @(posedge clk) begin
		if (rst) begin
			s_reg <= '0;
			s_reg.fs_width <= tfp_pkg::RST_FS_WIDTH;
			s_reg.frame_len <= tfp_pkg::RST_FRAME_LEN;
			s_reg.half <= tfp_pkg::RST_HALF;
		end else begin
			s_reg <= s_next;
		end
	end

	assign wb_ack_o = s_reg.wb_ack;
	assign wb_dat_o = s_reg.wb_dat;
	assign port_bit_clock_o = s_reg.bclk_o;
	assign port_bit_clock_oe = s_reg.bclk_oe;
	assign port_frame_sync_o = s_reg.fs_o;
	assign port_frame_sync_oe = s_reg.fs_oe;
	assign port_serial_out_o = s_reg.sd_o;
	assign port_serial_out_oe = s_reg.sd_oe;
endmodule
`default_nettype wire

// ### core/tfp_pkg.sv
// constants and shared types of the tdm frame timing port
package tfp_pkg;
	// clock rates and the bit-clock ceiling under the high-rate master clock
	localparam int unsigned CLK_RATE_KHZ  = 100000;
	localparam int unsigned BCLK_MAX_KHZ  = 6400;
	// least bit-clock period and half period in clk cycles, rounded up
	localparam logic [7:0]  MIN_PERIOD_CYC = 8'((CLK_RATE_KHZ + BCLK_MAX_KHZ - 1) / BCLK_MAX_KHZ);
	localparam logic [7:0]  MIN_HALF_CYC   = 8'((CLK_RATE_KHZ + 2 * BCLK_MAX_KHZ - 1) / (2 * BCLK_MAX_KHZ));

	// frame geometry
	localparam int unsigned SLOT_BITS   = 8;
	localparam int unsigned MAX_SLOTS   = 48;
	localparam int unsigned FLOW_SLOTS  = 3;
	localparam int unsigned FLOW_BITS   = FLOW_SLOTS * SLOT_BITS;
	localparam int unsigned TAIL_BITS   = 16;
	localparam int unsigned CH_COUNT    = 4;
	localparam logic [11:0] WINDOW_BITS = 12'(MAX_SLOTS * SLOT_BITS);
	localparam logic [11:0] TAIL_END    = 12'(MAX_SLOTS * SLOT_BITS + TAIL_BITS);

	// register byte offsets
	localparam logic [7:0] ADDR_CTRL     = 8'h00;
	localparam logic [7:0] ADDR_FS_WIDTH = 8'h04;
	localparam logic [7:0] ADDR_TIMING   = 8'h08;
	localparam logic [7:0] ADDR_SLOT_LO  = 8'h0C;
	localparam logic [7:0] ADDR_SLOT_HI  = 8'h10;
	localparam logic [7:0] ADDR_CH_LOC   = 8'h14;
	localparam logic [7:0] ADDR_CH_DATA0 = 8'h18;
	localparam logic [7:0] ADDR_STATUS   = 8'h28;

	// status fields
	localparam int unsigned ST_OVERRATE_BIT = 24;

	// values after reset
	localparam logic [7:0]  RST_HALF      = 8'h04;
	localparam logic [11:0] RST_FRAME_LEN = 12'h190;
	localparam logic [10:0] RST_FS_WIDTH  = 11'h001;

	// control bits steering the port
	typedef struct packed {
		logic high_rate;
		logic half_duty;
		logic invert;
		logic early;
		logic master;
		logic enable;
	} tfp_ctrl_t;

	// timing settings handed to the master clock generator
	typedef struct packed {
		logic        run;
		logic        invert;
		logic        half_duty;
		logic [7:0]  half;
		logic [11:0] frame_len;
		logic [10:0] fs_width;
	} tfp_gen_cfg_t;
endpackage

// ### core/tfp_master_gen.sv
// bit clock and frame sync generator for clock-master operation
`timescale 1ns/1ps
`default_nettype none
module tfp_master_gen (
	input  wire logic                  clk,
	input  wire logic                  rst,
	input  wire tfp_pkg::tfp_gen_cfg_t cfg,
	output logic                       bit_clock,
	output logic                       frame_sync
);
	typedef struct packed {
		logic [7:0]  div;
		logic        lvl;
		logic [11:0] cnt;
		logic        fs;
	} tfp_gen_state_t;

	tfp_gen_state_t s_reg;
	tfp_gen_state_t s_next;
	logic [11:0]    width;

	// the clock toggles every half period and never pauses while running
	always_comb begin
		s_next = s_reg;
		width = cfg.half_duty ? (cfg.frame_len >> 1) : {1'b0, cfg.fs_width}; // [RULE9]
		if (width == 12'h000) begin
			width = 12'h001;
		end
		if (!cfg.run) begin
			// park the count on the last bit so the first frame opens with a full sync pulse
			s_next = '0;
			s_next.cnt = cfg.frame_len - 12'h001;
		end else if (s_reg.div + 8'h01 >= cfg.half) begin
			s_next.div = 8'h00;
			s_next.lvl = ~s_reg.lvl; // [RULE14]
			// frame sync moves on the effective falling edge so the sampler sees it settled
			if ((~s_reg.lvl) == cfg.invert) begin
				s_next.cnt = (s_reg.cnt + 12'h001 >= cfg.frame_len) ? 12'h000 : s_reg.cnt + 12'h001;
				s_next.fs = s_next.cnt < width; // [RULE5]
			end
		end else begin
			s_next.div = s_reg.div + 8'h01;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	assign bit_clock = s_reg.lvl;
	assign frame_sync = s_reg.fs;
endmodule
`default_nettype wire

// ### dv/tfp_checker.sv
// concurrent checks on the tdm frame timing port pins and register bus
`timescale 1ns/1ps
`default_nettype none
module tfp_checker (
	input wire logic        clk,
	input wire logic        rst,
	input wire logic [7:0]  wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic        wb_we_i,
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_ack_o,
	input wire logic        port_bit_clock_i,
	input wire logic        port_bit_clock_o,
	input wire logic        port_bit_clock_oe,
	input wire logic        port_frame_sync_o,
	input wire logic        port_frame_sync_oe,
	input wire logic        port_serial_out_o,
	input wire logic        port_serial_out_oe
);
	logic [5:0]  ctrl_reg;
	logic [10:0] width_reg;
	logic [8:0]  bi_age_reg;
	logic [8:0]  bo_age_reg;
	logic [11:0] rise_reg;
	// shadows of control and sync width, taken on the edge where the design takes the write
	always_ff @(posedge clk) begin
		if (rst) begin
			ctrl_reg <= 6'h00;
			width_reg <= 11'h001;
		end else if (wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o) begin
			if (wb_adr_i == tfp_pkg::ADDR_CTRL) ctrl_reg <= wb_dat_i[5:0];
			if (wb_adr_i == tfp_pkg::ADDR_FS_WIDTH) width_reg <= wb_dat_i[10:0];
		end
	end
	// cycles since each clock pin moved; saturating so long idles never wrap to small values
	always_ff @(posedge clk) begin
		if (rst) begin
			bi_age_reg <= 9'h000;
			bo_age_reg <= 9'h000;
			rise_reg <= 12'h000;
		end else begin
			bi_age_reg <= $changed(port_bit_clock_i) ? 9'h000 : bi_age_reg + {8'h00, ~&bi_age_reg};
			bo_age_reg <= $changed(port_bit_clock_o) ? 9'h000 : bo_age_reg + {8'h00, ~&bo_age_reg};
			rise_reg <= !port_frame_sync_o ? 12'h000 : rise_reg + {11'h000, $rose(port_bit_clock_o)};
		end
	end
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);
	chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack stood too long");
	chk_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("no ack");
	chk_oe_pair: assert property (port_bit_clock_oe == port_frame_sync_oe)
		else $error("clock and sync drivers disagree");
	chk_slave_quiet: assert property (!ctrl_reg[1] [*3] |-> !port_bit_clock_oe)
		else $error("bit clock driven as slave");
	chk_clock_runs: assert property (port_bit_clock_oe [*2]
		|-> ##[0:300] ($changed(port_bit_clock_o) || !port_bit_clock_oe)) else $error("bit clock stalled");
	chk_rate_ceiling: assert property (ctrl_reg[5] && port_bit_clock_oe && $past(port_bit_clock_oe, 9)
		&& $changed(port_bit_clock_o) |-> bo_age_reg >= 9'h007) else $error("bit clock too fast");
	chk_fs_on_edge: assert property (port_frame_sync_oe && $past(port_frame_sync_oe, 4)
		&& $changed(port_frame_sync_o) |-> $changed(port_bit_clock_o) && port_bit_clock_o == ctrl_reg[3])
		else $error("sync moved off a clock edge");
	chk_fs_width: assert property ($fell(port_frame_sync_o) && port_frame_sync_oe && ctrl_reg[4:3] == 2'b00
		|-> rise_reg == {1'b0, width_reg} + {11'h000, width_reg == 11'h000}) else $error("sync width wrong");
	chk_slave_launch: assert property (!port_bit_clock_oe && port_serial_out_oe && $past(port_serial_out_oe)
		&& $changed(port_serial_out_o) |-> bi_age_reg <= 9'h004) else $error("data moved without a clock edge");
endmodule
`default_nettype wire

// ### dv/tfp_far_end.sv
// tdm clock master model: bit clock and frame sync, with optional burst clocking
`timescale 1ns/1ps
`default_nettype none
module tfp_far_end (
	input wire logic        clk,
	input wire logic        run,
	input wire logic        inv,
	input wire logic [7:0]  half,
	input wire logic [11:0] bits,
	input wire logic [11:0] burst,
	output logic            bit_clock,
	output logic            frame_sync
);
	logic [7:0]  tick;
	logic [12:0] ph;
	// half-period phases, even low and odd high; any rate is fine for the device
	always @(posedge clk) begin
		if (!run) begin
			tick <= 8'h00;
			ph <= 13'h0000;
		end else if (tick == half - 8'h01) begin
			tick <= 8'h00;
			ph <= (ph == {bits - 12'h001, 1'b1}) ? 13'h0000 : ph + 13'h0001;
		end else
			tick <= tick + 8'h01;
	end
	// clock stands still outside frames and once the burst is spent
	assign bit_clock = inv ^ (run && ph[0] && ph[12:1] < burst);
	// sync moves on effective falling edges only, high across the first rising edge
	assign frame_sync = run && ph[12:1] == 12'h000;
endmodule
`default_nettype wire

// ### dv/tfp_port_tb_top.sv
// self-checking bench for the tdm frame timing port
`timescale 1ns/1ps
`default_nettype none
module tfp_port_tb_top;
	logic        clk;
	logic        rst;
	logic [7:0]  wb_adr_i;
	logic [31:0] wb_dat_i;
	logic [3:0]  wb_sel_i;
	logic        wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o;
	logic [31:0] wb_dat_o;
	logic        port_bit_clock_o, port_bit_clock_oe, port_frame_sync_o, port_frame_sync_oe;
	logic        port_serial_out_o, port_serial_out_oe, far_clock, far_sync, run, inv, early;
	logic [11:0] burst;
	logic [47:0] en;
	logic [23:0] dat [4];
	logic [31:0] q;
	int          loc [4];
	int          k;
	int          mismatches;
	int          comparisons;
	// shared pins: the driving side wins, the model only drives while the port listens
	wire logic port_bit_clock_i = port_bit_clock_oe ? port_bit_clock_o : far_clock;
	wire logic port_frame_sync_i = port_frame_sync_oe ? port_frame_sync_o : far_sync;
	wire logic eff = port_bit_clock_i ^ inv;
	tfp_port DUT (.*);
	tfp_far_end FAR (.clk(clk), .run(run), .inv(inv), .half(8'h05), .bits(12'h190), .burst(burst),
		.bit_clock(far_clock), .frame_sync(far_sync));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task automatic end_sim;
		if (mismatches == 0 && comparisons > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			mismatches++;
			$display("ERROR %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic chk_line(input logic [1:0] got, input logic [1:0] exp);
		chk_word({30'h00000000, got}, {30'h00000000, exp});
	endtask
	// one classic cycle; waits for ack with no bound of its own, then idles a cycle
	task automatic wb(input logic [7:0] a, input logic we, input logic [31:0] d);
		wb_adr_i <= a;
		wb_we_i <= we;
		wb_dat_i <= d;
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		do begin
			@(posedge clk);
		end while (wb_ack_o !== 1'b1);
		q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		wb(a, 1'b0, 32'h00000000);
		chk_word(q & m, e);
	endtask
	// channel 0 spills past the window; 1 and 2 share a start; 3 follows them
	task automatic setup(input logic [47:0] e);
		en = e;
		loc[0] = 46;
		loc[1] = 3 * int'($urandom % 14);
		loc[2] = loc[1];
		loc[3] = loc[1] + 3;
		wb(tfp_pkg::ADDR_SLOT_LO, 1'b1, e[31:0]);
		wb(tfp_pkg::ADDR_SLOT_HI, 1'b1, {16'h0000, e[47:32]});
		wb(tfp_pkg::ADDR_CH_LOC, 1'b1, {2'h0, 6'(loc[3]), 2'h0, 6'(loc[2]), 2'h0, 6'(loc[1]), 2'h0, 6'(loc[0])});
		for (int c = 0; c < 4; c++) begin
			dat[c] = 24'($urandom);
			wb(tfp_pkg::ADDR_CH_DATA0 + 8'(4 * c), 1'b1, {8'h00, dat[c]});
		end
	endtask
	task automatic frames(input logic [7:0] ctl, input int n);
		early = ctl[2];
		inv <= ctl[3];
		k = -100000;
		wb(tfp_pkg::ADDR_CTRL, 1'b1, {24'h000000, ctl});
		run <= 1'b1;
		repeat (n * 4000) @(posedge clk);
		run <= 1'b0;
		@(posedge clk);
	endtask
	// pin state for frame bit i: slot enable, data msb first from the lowest covering channel
	function automatic logic [1:0] exp_bit(input int i);
		logic d;
		logic e;
		d = 1'b0;
		e = (i < 384) ? en[i / 8] : en[47];
		for (int c = 3; c >= 0; c--) begin
			if (i >= loc[c] * 8 && i < loc[c] * 8 + 24) d = dat[c][23 - (i - loc[c] * 8)];
		end
		return {e, e & d & (i < 400)};
	endfunction
	// receiver samples on the edge opposite the launch edge
	always @(posedge eff) begin
		k = port_bit_clock_oe ? -100000 : (port_frame_sync_i ? -1 : k + 1); // master edges never index a frame
		if (early && k >= 0 && !port_bit_clock_oe) chk_line({port_serial_out_oe, port_serial_out_oe & port_serial_out_o}, exp_bit(k));
	end
	always @(negedge eff) begin
		if (!early && k >= 0 && !port_bit_clock_oe) chk_line({port_serial_out_oe, port_serial_out_oe & port_serial_out_o}, exp_bit(k));
	end
	initial begin
		repeat (60000) @(posedge clk);
		mismatches++;
		end_sim;
	end
	initial begin
		{rst, wb_adr_i, wb_dat_i, wb_sel_i} = {1'b1, 8'h00, 32'h00000000, 4'hF};
		{wb_we_i, wb_cyc_i, wb_stb_i, run, inv, early, burst} = {6'h00, 12'hFFF};
		{k, mismatches, comparisons} = {-100000, 0, 0};
		void'($urandom(32'h44610C4C));
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		rd_chk(tfp_pkg::ADDR_CTRL, 32'hFFFFFFFF, 32'h00000000);
		rd_chk(tfp_pkg::ADDR_FS_WIDTH, 32'hFFFFFFFF, 32'h00000001);
		rd_chk(tfp_pkg::ADDR_TIMING, 32'hFFFFFFFF, 32'h00040190);
		wb(8'h3C, 1'b1, 32'hFFFFFFFF);
		rd_chk(8'h3C, 32'hFFFFFFFF, 32'h00000000);
		setup({1'b1, 15'($urandom), 32'($urandom)});
		for (int f = 0; f < 4; f++) frames(8'(f * 4 + 1), 2);
		rd_chk(tfp_pkg::ADDR_STATUS, 32'h003F0FFF, 32'h00300190);
		setup({1'b0, 15'($urandom), 32'($urandom)});
		burst <= 12'h0C8;
		frames(8'h01, 2);
		rd_chk(tfp_pkg::ADDR_STATUS, 32'h003F0FFF, 32'h001900C8);
		burst <= 12'hFFF;
		frames(8'h21, 1);
		rd_chk(tfp_pkg::ADDR_STATUS, 32'h01000000, 32'h01000000);
		wb(tfp_pkg::ADDR_STATUS, 1'b1, 32'h01000000);
		rd_chk(tfp_pkg::ADDR_STATUS, 32'h01000000, 32'h00000000);
		wb(tfp_pkg::ADDR_FS_WIDTH, 1'b1, 32'h00000003);
		wb(tfp_pkg::ADDR_TIMING, 1'b1, 32'h00020028);
		wb(tfp_pkg::ADDR_CTRL, 1'b1, 32'h00000023);
		repeat (3000) @(posedge clk);
		chk_line({port_bit_clock_oe, port_frame_sync_oe}, 2'h3);
		rd_chk(tfp_pkg::ADDR_STATUS, 32'h003F0FFF, 32'h00050028);
		wb(tfp_pkg::ADDR_CTRL, 1'b1, 32'h00000000);
		repeat (4) @(posedge clk);
		chk_line({port_bit_clock_oe, port_serial_out_oe}, 2'h0);
		end_sim;
	end
endmodule
bind tfp_port tfp_checker CHK (.*);
`default_nettype wire
